// ---- hw/arsc_top.sv ----
// Purpose: Reference and ground selection for the converter, plus offset registers
// Assumes: Core drives SFR strobes synchronous to SYS_CLK; reads return next cycle
// Notes:   Converter phase inputs come from converter logic on the same clock
`timescale 1ns/10ps
`default_nettype none

module arsc_top (
   input  wire logic                     SYS_CLK,     // 250 MHz system clock
   input  wire logic                     NRST,        // Async reset, active low
   input  wire arsc_pkg::arsc_sfr_req_s  SFR_REQ,     // Core register access
   output logic                    [7:0] SFR_RDATA,   // Read data, one cycle later
   output logic                          SFR_RVLD,    // Read data valid pulse
   input  wire logic                     CNV_TRACK,   // Converter tracking phase
   input  wire logic                     CNV_CONVERT, // Converter conversion phase
   input  wire logic               [4:0] CNV_MUX,     // Converter input select
   input  wire logic                     TRIM_VLD,    // Factory trim present
   input  wire logic               [9:0] TRIM_WORD,   // Factory trim offset value
   output var arsc_pkg::arsc_ana_sel_s   ANA_SEL      // Selections to analog side
);
   logic [1:0] ref_sel_q;
   logic [1:0] ref_sel_d;
   logic       gnd_sel_q;
   logic       gnd_sel_d;
   logic       sens_en_q;
   logic       sens_en_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       rvld_q;
   logic       rvld_d;
   arsc_pkg::arsc_ana_sel_s sel_q;
   arsc_pkg::arsc_ana_sel_s sel_d;
   logic [9:0] offset_val;
   logic       offset_loaded;

   arsc_trim_load u_trim (
      .clk       (SYS_CLK),
      .nrst      (NRST),
      .trim_vld  (TRIM_VLD),
      .trim_word (TRIM_WORD),
      .value     (offset_val),
      .loaded    (offset_loaded)
   );

   function automatic logic [7:0] ctrl_image(input logic g, input logic [1:0] r,
                                            input logic t);
      logic [7:0] img;
      img = 8'h00;
      img[arsc_pkg::GND_SEL_BIT] = g;
      img[arsc_pkg::REF_SEL_HI:arsc_pkg::REF_SEL_LO] = r;
      img[arsc_pkg::SENSOR_EN_BIT] = t;
      return img;
   endfunction : ctrl_image

   // Register writes and reads
   always_comb begin
      ref_sel_d = ref_sel_q;
      gnd_sel_d = gnd_sel_q;
      sens_en_d = sens_en_q;
      rdata_d   = rdata_q;
      rvld_d    = 1'b0;
      if (SFR_REQ.wr && SFR_REQ.addr == arsc_pkg::ADDR_REF_CONTROL) begin
         gnd_sel_d = SFR_REQ.wdata[arsc_pkg::GND_SEL_BIT];
         ref_sel_d = SFR_REQ.wdata[arsc_pkg::REF_SEL_HI:arsc_pkg::REF_SEL_LO];
         sens_en_d = SFR_REQ.wdata[arsc_pkg::SENSOR_EN_BIT];
      end
      if (SFR_REQ.rd) begin
         rvld_d = 1'b1;
         unique case (SFR_REQ.addr)
            arsc_pkg::ADDR_TEMP_OFFSET_HIGH: rdata_d = offset_val[9:2];
            arsc_pkg::ADDR_TEMP_OFFSET_LOW:
               rdata_d = {offset_val[1:0], 6'h00};
            arsc_pkg::ADDR_REF_CONTROL:
               rdata_d = ctrl_image(gnd_sel_q, ref_sel_q, sens_en_q);
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Analog selections
   always_comb begin
      sel_d = '0;
      sel_d.vref_ext_pin  = (ref_sel_q == arsc_pkg::ARSC_REF_EXT_PIN);
      sel_d.vref_main_sup = (ref_sel_q == arsc_pkg::ARSC_REF_MAIN_SUP);
      sel_d.vref_dig_sup  = (ref_sel_q == arsc_pkg::ARSC_REF_DIG_SUP);
      sel_d.vref_hs_int   = (ref_sel_q == arsc_pkg::ARSC_REF_HS_INT);
      sel_d.hs_ref_enable = sel_d.vref_hs_int && (CNV_TRACK || CNV_CONVERT);
      sel_d.gnd_from_analog_ground_pin = gnd_sel_q;
      if (CNV_TRACK && CNV_MUX == arsc_pkg::MUX_TEMP_SENSOR) begin
         sel_d.gnd_from_analog_ground_pin = 1'b0;
      end
      if (CNV_CONVERT && sel_d.vref_hs_int) begin
         sel_d.gnd_from_analog_ground_pin = 1'b0;
      end
      sel_d.sensor_enable = sens_en_q;
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         ref_sel_q <= arsc_pkg::REF_SEL_RESET;
         gnd_sel_q <= arsc_pkg::GND_SEL_RESET;
         sens_en_q <= arsc_pkg::SENSOR_EN_RESET;
         rdata_q   <= 8'h00;
         rvld_q    <= 1'b0;
         sel_q     <= '0;
      end else begin
         ref_sel_q <= ref_sel_d;
         gnd_sel_q <= gnd_sel_d;
         sens_en_q <= sens_en_d;
         rdata_q   <= rdata_d;
         rvld_q    <= rvld_d;
         sel_q     <= sel_d;
      end
   end

   assign SFR_RDATA = rdata_q;
   assign SFR_RVLD  = rvld_q;
   assign ANA_SEL   = sel_q;

   // Assertions
   a_offset_high_read: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      SFR_REQ.rd && SFR_REQ.addr == arsc_pkg::ADDR_TEMP_OFFSET_HIGH
      |=> SFR_RVLD && SFR_RDATA == $past(offset_val[9:2]))
      else $error("offset high read wrong");

   a_offset_low_read: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      SFR_REQ.rd && SFR_REQ.addr == arsc_pkg::ADDR_TEMP_OFFSET_LOW
      |=> SFR_RDATA[7:6] == $past(offset_val[1:0]))
      else $error("offset low read wrong");

   a_low_unused_zero: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      $past(SFR_REQ.rd) && $past(SFR_REQ.addr) == arsc_pkg::ADDR_TEMP_OFFSET_LOW
      |-> SFR_RDATA[5:0] == 6'h00)
      else $error("offset low unused bits not zero");

   a_ref_ext_pin: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ANA_SEL.vref_ext_pin |-> !ANA_SEL.vref_hs_int && $past(ref_sel_q) == 2'h0)
      else $error("external reference wrongly selected");

   a_ref_hs_sel: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ref_sel_q == 2'h3 |=> ANA_SEL.vref_hs_int)
      else $error("high-speed reference not selected");

   a_hs_ref_demand: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ANA_SEL.hs_ref_enable == $past(ref_sel_q == 2'h3 && (CNV_TRACK || CNV_CONVERT)))
      else $error("high-speed reference enable wrong");

   a_supply_refs: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ref_sel_q == 2'h1 |=> ANA_SEL.vref_main_sup && !ANA_SEL.vref_dig_sup)
      else $error("supply reference wrong");

   a_sensor_gnd: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      CNV_TRACK && CNV_MUX == arsc_pkg::MUX_TEMP_SENSOR |=> !ANA_SEL.gnd_from_analog_ground_pin)
      else $error("sensor sampling not on internal ground");

   a_hs_conv_gnd: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      CNV_CONVERT && ref_sel_q == 2'h3 |=> !ANA_SEL.gnd_from_analog_ground_pin)
      else $error("conversion not on internal ground");

   a_analog_ground_pin_select: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      gnd_sel_q && !CNV_TRACK && !CNV_CONVERT |=> ANA_SEL.gnd_from_analog_ground_pin)
      else $error("analog ground pin not used");

   a_ctrl_write: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      SFR_REQ.wr && SFR_REQ.addr == arsc_pkg::ADDR_REF_CONTROL
      |=> ##1 ANA_SEL.sensor_enable == $past(SFR_REQ.wdata[2], 2))
      else $error("sensor enable write not applied");

   a_dig_supply_ref: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ref_sel_q == 2'h2
      |=> ANA_SEL.vref_dig_sup && !ANA_SEL.vref_main_sup)
      else $error("digital supply reference wrong");

   a_ext_pin_code: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ref_sel_q == 2'h0
      |=> ANA_SEL.vref_ext_pin)
      else $error("external reference not selected");

   a_ref_one_source: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      $past(NRST) |-> $onehot({ANA_SEL.vref_ext_pin, ANA_SEL.vref_main_sup,
                               ANA_SEL.vref_dig_sup, ANA_SEL.vref_hs_int}))
      else $error("reference selection not one-hot");

   a_hs_ref_track: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ref_sel_q == 2'h3 && CNV_TRACK
      |=> ANA_SEL.hs_ref_enable)
      else $error("high-speed reference off while tracking");

   a_hs_ref_idle: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ref_sel_q == 2'h3 && !CNV_TRACK && !CNV_CONVERT
      |=> !ANA_SEL.hs_ref_enable)
      else $error("high-speed reference on while idle");

   a_hs_ref_unsel: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ref_sel_q != 2'h3
      |=> !ANA_SEL.hs_ref_enable)
      else $error("high-speed reference on while not selected");

   a_analog_ground_pin_track: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      gnd_sel_q && CNV_TRACK && !CNV_CONVERT && CNV_MUX != arsc_pkg::MUX_TEMP_SENSOR
      |=> ANA_SEL.gnd_from_analog_ground_pin)
      else $error("analog ground pin not used while tracking");

   a_analog_ground_pin_convert: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      gnd_sel_q && CNV_CONVERT && !CNV_TRACK && ref_sel_q != 2'h3
      |=> ANA_SEL.gnd_from_analog_ground_pin)
      else $error("analog ground pin not used while converting");

   a_gnd_pin_default: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      !gnd_sel_q
      |=> !ANA_SEL.gnd_from_analog_ground_pin)
      else $error("analog ground pin used with select clear");

   a_sensor_follow: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ANA_SEL.sensor_enable == $past(sens_en_q))
      else $error("sensor enable does not follow register");

   a_sensor_write_off: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      SFR_REQ.wr && SFR_REQ.addr == arsc_pkg::ADDR_REF_CONTROL && !SFR_REQ.wdata[2]
      |=> ##1 !ANA_SEL.sensor_enable)
      else $error("sensor not switched off");

   a_reset_values: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      !$past(NRST)
      |-> ref_sel_q == arsc_pkg::REF_SEL_RESET && !gnd_sel_q && !sens_en_q)
      else $error("control reset values wrong");

   a_ctrl_unused_zero: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      $past(SFR_REQ.rd && SFR_REQ.addr == arsc_pkg::ADDR_REF_CONTROL)
      |-> SFR_RDATA[7:6] == 2'h0 && SFR_RDATA[1:0] == 2'h0)
      else $error("control unused bits not zero");

   a_ctrl_read_image: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      SFR_REQ.rd && SFR_REQ.addr == arsc_pkg::ADDR_REF_CONTROL
      |=> SFR_RDATA[5] == $past(gnd_sel_q) && SFR_RDATA[4:3] == $past(ref_sel_q)
          && SFR_RDATA[2] == $past(sens_en_q))
      else $error("control read image wrong");

   a_ctrl_write_ref: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      SFR_REQ.wr && SFR_REQ.addr == arsc_pkg::ADDR_REF_CONTROL
      |=> ref_sel_q == $past(SFR_REQ.wdata[4:3]) && gnd_sel_q == $past(SFR_REQ.wdata[5]))
      else $error("control write not applied");

   a_ctrl_hold: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      !(SFR_REQ.wr && SFR_REQ.addr == arsc_pkg::ADDR_REF_CONTROL)
      |=> $stable(ref_sel_q) && $stable(gnd_sel_q) && $stable(sens_en_q))
      else $error("control changed without write");

   a_read_valid: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      SFR_REQ.rd
      |=> SFR_RVLD)
      else $error("read valid missing");

   a_read_valid_idle: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      !SFR_REQ.rd
      |=> !SFR_RVLD)
      else $error("read valid without read");

   a_rdata_hold: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      !SFR_REQ.rd
      |=> $stable(SFR_RDATA))
      else $error("read data changed without read");

   a_unmapped_read: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      SFR_REQ.rd && SFR_REQ.addr != arsc_pkg::ADDR_TEMP_OFFSET_LOW
      && SFR_REQ.addr != arsc_pkg::ADDR_TEMP_OFFSET_HIGH
      && SFR_REQ.addr != arsc_pkg::ADDR_REF_CONTROL
      |=> SFR_RDATA == 8'h00)
      else $error("unmapped read not zero");

   a_offset_write_ignored: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      offset_loaded && SFR_REQ.wr && (SFR_REQ.addr == arsc_pkg::ADDR_TEMP_OFFSET_LOW
      || SFR_REQ.addr == arsc_pkg::ADDR_TEMP_OFFSET_HIGH)
      |=> $stable(offset_val) && $stable(ref_sel_q))
      else $error("offset register write had an effect");

   a_offset_stable: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      offset_loaded
      |=> $stable(offset_val) && offset_loaded)
      else $error("offset value changed after capture");
endmodule : arsc_top
`default_nettype wire

// ---- hw/arsc_pkg.sv ----
// Purpose: Shared constants and types for the converter reference select control
// Assumes: 8-bit special-function register space, single clock
// Notes:   Trim value is arbitrary and only a default for simulation
package arsc_pkg;

   localparam logic [7:0] ADDR_TEMP_OFFSET_LOW  = 8'h85;
   localparam logic [7:0] ADDR_TEMP_OFFSET_HIGH = 8'h86;
   localparam logic [7:0] ADDR_REF_CONTROL      = 8'hD1;

   localparam int GND_SEL_BIT   = 5;
   localparam int REF_SEL_HI    = 4;
   localparam int REF_SEL_LO    = 3;
   localparam int SENSOR_EN_BIT = 2;
   localparam int OFFS_LOW_POS  = 6;

   localparam logic [1:0] REF_SEL_RESET    = 2'h3;
   localparam logic       GND_SEL_RESET    = 1'h0;
   localparam logic       SENSOR_EN_RESET  = 1'h0;
   localparam logic [9:0] TRIM_DEFAULT     = 10'h155;
   localparam logic [4:0] MUX_TEMP_SENSOR  = 5'h1B;

   typedef enum logic [1:0] {
      ARSC_REF_EXT_PIN  = 2'h0,
      ARSC_REF_MAIN_SUP = 2'h1,
      ARSC_REF_DIG_SUP  = 2'h2,
      ARSC_REF_HS_INT   = 2'h3
   } arsc_ref_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } arsc_sfr_req_s;

   typedef struct packed {
      logic vref_ext_pin;
      logic vref_main_sup;
      logic vref_dig_sup;
      logic vref_hs_int;
      logic hs_ref_enable;
      logic gnd_from_analog_ground_pin;
      logic sensor_enable;
   } arsc_ana_sel_s;

endpackage : arsc_pkg

// ---- hw/arsc_trim_load.sv ----
// Purpose: Captures the factory offset trim once reset is released
// Assumes: Trim word from non-volatile storage is stable while valid is high
// Notes:   Trim input is asynchronous to this clock, so it is synchronised
`timescale 1ns/10ps
`default_nettype none
module arsc_trim_load (
   input  wire logic       clk,        // System clock
   input  wire logic       nrst,       // Async reset, active low
   input  wire logic       trim_vld,   // Trim word present
   input  wire logic [9:0] trim_word,  // Factory offset value
   output logic      [9:0] value,      // Held offset value
   output logic            loaded      // Value captured
);
   logic [2:0] vld_sync_q;
   logic [2:0] vld_sync_d;
   logic [9:0] value_q;
   logic [9:0] value_d;
   logic       loaded_q;
   logic       loaded_d;

   always_comb begin
      vld_sync_d = {vld_sync_q[1:0], trim_vld};
      value_d    = value_q;
      loaded_d   = loaded_q;
      if (!loaded_q && vld_sync_q[1] && vld_sync_q[2]) begin
         value_d  = trim_word;
         loaded_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         vld_sync_q <= 3'h0;
         value_q    <= arsc_pkg::TRIM_DEFAULT;
         loaded_q   <= 1'b0;
      end else begin
         vld_sync_q <= vld_sync_d;
         value_q    <= value_d;
         loaded_q   <= loaded_d;
      end
   end

   assign value  = value_q;
   assign loaded = loaded_q;
endmodule : arsc_trim_load
`default_nettype wire

// ---- test/arsc_conv_model.sv ----
// Purpose: Converter model that runs one track then convert frame per request
// Assumes: Phases never overlap; outputs change only at the falling edge
// Notes:   Slow mode stretches each phase to six cycles
`timescale 1ns/10ps
`default_nettype none
module arsc_conv_model (
   input  wire logic       clk,    // System clock
   input  wire logic       go,     // Start one frame
   input  wire logic       slow,   // Stretch each phase
   input  wire logic [4:0] mux_in, // Channel for the frame
   output logic            track,  // Tracking phase
   output logic            conv,   // Conversion phase
   output logic      [4:0] mux,    // Channel select
   output logic            busy    // Frame in progress
);
   int cnt;
   initial begin
      {track, conv, busy, cnt} = '0;
      mux = 5'h00;
   end
   always @(negedge clk) begin
      if (go && !busy) begin
         {busy, track, mux} <= {2'h3, mux_in};
         cnt <= slow ? 6 : 1;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (track) begin
         {track, conv} <= 2'h1;
         cnt <= slow ? 6 : 1;
      end else if (conv) begin
         {conv, busy} <= 2'h0;
         mux <= ~mux;
      end
   end
endmodule : arsc_conv_model
`default_nettype wire

// ---- test/arsc_top_tb.sv ----
// Purpose: Self-checking bench for the reference select control
// Assumes: Inputs change at the falling edge; reads answer one cycle later
// Notes:   Read results go through a queue; selections are checked every cycle while chk_on is set
`timescale 1ns/10ps
`default_nettype none
`define CHK(A, E) begin tests_run++; if ((A) !== (E)) begin err_total++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, A, E); end end
module arsc_top_tb;
   logic                    sys_clk = 1'b0, nrst = 1'b0, go = 1'b0, slow = 1'b0;
   logic                    rvld, trk, cnv, busy, chk_on = 1'b0, trim_vld = 1'b1;
   logic              [7:0] rdata, e8, exp_q[$];
   logic              [4:0] mux, mux_in = 5'h00;
   logic              [9:0] trim, old;
   logic              [3:0] ctl = 4'h6;
   logic             [31:0] r = 32'h12D7;
   int                      err_total = 0, tests_run = 0, cyc = 0;
   arsc_pkg::arsc_sfr_req_s req = '0;
   arsc_pkg::arsc_ana_sel_s sel;

   arsc_top i_dut (.SYS_CLK(sys_clk), .NRST(nrst), .SFR_REQ(req), .SFR_RDATA(rdata),
      .SFR_RVLD(rvld), .CNV_TRACK(trk), .CNV_CONVERT(cnv), .CNV_MUX(mux),
      .TRIM_VLD(trim_vld), .TRIM_WORD(trim), .ANA_SEL(sel));
   arsc_conv_model i_conv (.clk(sys_clk), .go(go), .slow(slow), .mux_in(mux_in),
      .track(trk), .conv(cnv), .mux(mux), .busy(busy));

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   // Control word is {ground select, reference select, sensor enable}
   function automatic arsc_pkg::arsc_ana_sel_s exp_sel(input logic [3:0] c,
         input logic t, v, input logic [4:0] m);
      arsc_pkg::arsc_ana_sel_s s;
      s.vref_ext_pin  = c[2:1] == arsc_pkg::ARSC_REF_EXT_PIN;
      s.vref_main_sup = c[2:1] == arsc_pkg::ARSC_REF_MAIN_SUP;
      s.vref_dig_sup  = c[2:1] == arsc_pkg::ARSC_REF_DIG_SUP;
      s.vref_hs_int   = c[2:1] == arsc_pkg::ARSC_REF_HS_INT;
      s.hs_ref_enable = s.vref_hs_int && (t || v);
      s.gnd_from_analog_ground_pin = c[3] && !(t && m == arsc_pkg::MUX_TEMP_SENSOR)
                        && !(s.vref_hs_int && v);
      s.sensor_enable = c[0];
      return s;
   endfunction : exp_sel

   task automatic sfr(input logic w, input logic [7:0] a, d, e);
      @(negedge sys_clk);
      {req.addr, req.wdata, req.wr, req.rd} = {a, d, w, ~w};
      if (!w) exp_q.push_back(e);
      @(negedge sys_clk);
      {req.addr, req.wdata, req.wr, req.rd} = {~a, ~d, 2'h0};
   endtask : sfr

   task automatic close_out();
      $display("comparisons=%0d mismatches=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out

   always @(negedge sys_clk) begin
      if (rvld === 1'b1) begin
         e8 = (exp_q.size() > 0) ? exp_q.pop_front() : ~rdata;
         `CHK(rdata, e8)
      end
      if (chk_on)
         `CHK(sel, exp_sel(ctl, trk, cnv, mux))
   end

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         close_out();
      end
   end

   initial begin
      trim = r[9:0];
      old  = trim;
      repeat (8) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (8) @(negedge sys_clk);
      chk_on = 1'b1;
      sfr(1'b0, arsc_pkg::ADDR_REF_CONTROL, 8'h00, 8'h18);
      trim = ~trim;
      for (int p = 0; p < 2; p++) begin
         sfr(1'b0, arsc_pkg::ADDR_TEMP_OFFSET_HIGH, 8'h00, old[9:2]);
         sfr(1'b0, arsc_pkg::ADDR_TEMP_OFFSET_LOW, 8'h00, {old[1:0], 6'h00});
         sfr(1'b1, arsc_pkg::ADDR_TEMP_OFFSET_LOW, 8'hFF, 8'h00);
         sfr(1'b1, arsc_pkg::ADDR_TEMP_OFFSET_HIGH, ~old[9:2], 8'h00);
      end
      sfr(1'b0, 8'h40, 8'h00, 8'h00);
      for (int i = 0; i < 32; i++) begin
         r = lfsr(r);
         chk_on = 1'b0;
         sfr(1'b1, arsc_pkg::ADDR_REF_CONTROL, {r[7:6], i[3:0], r[1:0]}, 8'h00);
         repeat (2) @(negedge sys_clk);
         ctl = i[3:0];
         chk_on = 1'b1;
         sfr(1'b0, arsc_pkg::ADDR_REF_CONTROL, 8'h00, {2'h0, i[3:0], 2'h0});
         mux_in <= i[4] ? arsc_pkg::MUX_TEMP_SENSOR : r[12:8];
         slow   <= r[2];
         go     <= 1'b1;
         @(negedge sys_clk);
         go <= 1'b0;
         repeat (2) @(negedge sys_clk);
         while (busy) @(negedge sys_clk);
         @(negedge sys_clk);
      end
      repeat (3) @(negedge sys_clk);
      close_out();
   end
endmodule : arsc_top_tb
`default_nettype wire
